// ---- rtc_cfg_regs.svh ----
// Register offsets, field positions, reset values and timing counts
`ifndef RTC_CFG_REGS_SVH
`define RTC_CFG_REGS_SVH

// ----------------------------------------------------------------
// Register offsets (word index on the register port)
// ----------------------------------------------------------------
`define OFS_CAL_CFG 4'h0
`define OFS_PAD_CFG 4'h1
`define OFS_ALARM_CFG 4'h2
`define OFS_MIN_SEC 4'h3
`define OFS_IRQ_STATUS 4'h4
`define OFS_IRQ_MASK 4'h5
`define OFS_CTRL 4'h6

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CAL_LSB 0
`define CAL_MSB 7
`define BIT_HALF_SEC 11
`define BIT_WREN 13
`define BIT_CLK_EN 15
`define SEL_LSB 1
`define SEL_MSB 2
`define BIT_PMP_TTL 0
`define BIT_ALARM_EN 15
`define BIT_CHIME 14
`define ALARM_PERIOD_MASK_LSB 10
`define ALARM_PERIOD_MASK_MSB 13
`define APTR_LSB 8
`define APTR_MSB 9
`define ALARM_REPEAT_COUNT_LSB 0
`define ALARM_REPEAT_COUNT_MSB 7
`define BIT_OSC_SEL 0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_CAL_CFG 16'h0000
`define RST_PAD_CFG 16'h0000
`define RST_ALARM_CFG 16'h0000

// ----------------------------------------------------------------
// Timing: timebase ticks per second and half second, seconds per minute, pulse step
// ----------------------------------------------------------------
`define TICKS_PER_SEC 16'h8000
`define HALF_SEC_TICKS 16'h4000
`define SECS_PER_MIN 6'h3c
`define CAL_STEP 3

`endif

// ---- rtc_cfg_pkg.sv ----
// Types shared by the clock configuration block
package rtc_cfg_pkg;

	typedef enum logic [1:0] {
		sel_alarm,
		sel_seconds,
		sel_source,
		sel_reserved
	} out_sel_type;

	typedef enum logic [1:0] {
		ev_alarm,
		ev_second,
		ev_minute,
		ev_half
	} event_idx_type;

endpackage : rtc_cfg_pkg

// ---- tick_if.sv ----
// Timebase events passed from the counter to the main block
`timescale 1ns/10ps
interface tick_if;
	logic tick;
	logic second_pulse;
	logic minute_pulse;
	logic half_sec;
	logic sec_clk;
	modport src (output tick, second_pulse, minute_pulse, half_sec, sec_clk);
	modport dst (input tick, second_pulse, minute_pulse, half_sec, sec_clk);
endinterface : tick_if

// ---- pin_sync.sv ----
// Three-stage synchroniser with agreement of the last two stages
`timescale 1ns/10ps
module pin_sync (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Raw pin and clean level
	input wire logic pin,
	output logic level
);
	typedef struct packed {
		logic [2:0] sh;
		logic lvl;
	} sync_state_type;

	sync_state_type st_ff;
	sync_state_type nxt_st;

	// Stage 0 feeds only stage 1; the output moves once 1 and 2 agree
	always_comb begin
		nxt_st = st_ff;
		nxt_st.sh = {st_ff.sh[1:0], pin};
		if (st_ff.sh[1] == st_ff.sh[2]) begin
			nxt_st.lvl = st_ff.sh[2];
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign level = st_ff.lvl;
endmodule : pin_sync

// ---- tick_gen.sv ----
// Timebase pulse counter with once-a-minute drift calibration
`timescale 1ns/10ps
`include "rtc_cfg_regs.svh"
module tick_gen (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Synchronised timebase level and control
	input wire logic src_level,
	input wire logic run,
	input wire logic [7:0] cal,
	// Events out
	tick_if.src tk
);
	typedef struct packed {
		logic prev;
		logic [15:0] cnt;
		logic [5:0] secs;
		logic [9:0] adj;
		logic adj_add;
		logic sec_p;
		logic min_p;
		logic tk;
	} tg_state_type;

	tg_state_type st_ff;
	tg_state_type nxt_st;
	logic edge_seen;
	logic [9:0] mag;

	assign edge_seen = src_level & ~st_ff.prev;
	// Step of four pulses: signed code times four gives -512..+508
	assign mag = cal[7] ? 10'((~{2'b11, cal} + 10'h001) << `CAL_STEP - 1)
		: 10'({2'b00, cal} << `CAL_STEP - 1);

	always_comb begin
		nxt_st = st_ff;
		nxt_st.prev = src_level;
		nxt_st.sec_p = 1'b0;
		nxt_st.min_p = 1'b0;
		nxt_st.tk = 1'b0;
		if (run && edge_seen) begin
			nxt_st.tk = 1'b1;
			if (st_ff.adj != 10'h000 && !st_ff.adj_add) begin
				nxt_st.adj = st_ff.adj - 10'h001;
			end else begin
				if (st_ff.adj != 10'h000) begin
					nxt_st.adj = st_ff.adj - 10'h001;
					nxt_st.cnt = st_ff.cnt + 16'h0002;
				end else begin
					nxt_st.cnt = st_ff.cnt + 16'h0001;
				end
				if (nxt_st.cnt >= `TICKS_PER_SEC) begin
					nxt_st.cnt = nxt_st.cnt - `TICKS_PER_SEC;
					nxt_st.sec_p = 1'b1;
					if (st_ff.secs == `SECS_PER_MIN - 6'h01) begin
						nxt_st.secs = 6'h00;
						nxt_st.min_p = 1'b1;
						nxt_st.adj = mag;
						nxt_st.adj_add = ~cal[7];
					end else begin
						nxt_st.secs = st_ff.secs + 6'h01;
					end
				end
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign tk.tick = st_ff.tk;
	assign tk.second_pulse = st_ff.sec_p;
	assign tk.minute_pulse = st_ff.min_p;
	assign tk.half_sec = (st_ff.cnt >= `HALF_SEC_TICKS);
	assign tk.sec_clk = ~tk.half_sec;
endmodule : tick_gen

// ---- rtc_cfg.sv ----
// Clock configuration: calibration, output select, alarm config
//
// Behaviour
// - Calibration code 0x7f adds 508 timebase pulses each minute.
// - Each positive calibration step adds four pulses per minute.
// - A zero calibration code leaves the timebase untouched.
// - Code 0xff removes four timebase pulses each minute.
// - Code 0x80 removes 512 pulses each minute.
// - The calibration register is cleared only by power-on reset.
// - Writes to the clock enable bit need the write enable set.
// - The half-second flag is read-only and cleared by a low write.
// - Output select 00 drives the alarm pulse to the output pin.
// - Output select 01 drives the one-second clock to the pin.
// - Output select 10 drives the chosen synchronised timebase to the pin.
//
// The address map and the plain strobed port were decided locally.
`timescale 1ns/10ps
`include "rtc_cfg_regs.svh"
module rtc_cfg (
	// Clock and resets
	input wire logic clk,
	input wire logic nrst,
	input wire logic por_nrst,
	// Register port
	input wire logic [3:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [15:0] rdata,
	// Timebase pins
	input wire logic internal_low_power_rc,
	input wire logic secondary_crystal_osc,
	// Alarm match from the comparator
	input wire logic alarm_match,
	// Outputs
	output logic clock_output_pin,
	output logic parallel_port_buffer_select,
	output logic irq
);
	import rtc_cfg_pkg::*;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [15:0] rdata;
		logic [15:0] pad;
		logic [15:0] alarm;
		logic osc_sel;
		logic half_clr;
		logic [3:0] status;
		logic [3:0] mask;
		logic alarm_pulse;
		logic pin;
		logic irq;
	} main_state_type;

	// Calibration register lives in its own power-on domain
	typedef struct packed {
		logic [7:0] cal;
		logic clk_en;
		logic wren;
	} por_state_type;

	main_state_type st_ff;
	main_state_type nxt_st;
	por_state_type cal_ff;
	por_state_type nxt_cal;

	logic rc_lvl;
	logic secondary_crystal_osc_lvl;
	logic src_lvl;
	logic half_flag;
	logic [3:0] events;

	tick_if tk ();

	// ------------------------------------------------------------
	// Pin synchronisers for the two timebase sources
	// ------------------------------------------------------------
	pin_sync u_sync_rc (
		.clk(clk),
		.nrst(nrst),
		.pin(internal_low_power_rc),
		.level(rc_lvl)
	);

	pin_sync u_sync_secondary_crystal_osc (
		.clk(clk),
		.nrst(nrst),
		.pin(secondary_crystal_osc),
		.level(secondary_crystal_osc_lvl)
	);

	assign src_lvl = st_ff.osc_sel ? secondary_crystal_osc_lvl : rc_lvl;

	tick_gen u_tick (
		.clk(clk),
		.nrst(nrst),
		.src_level(src_lvl),
		.run(cal_ff.clk_en),
		.cal(cal_ff.cal),
		.tk(tk.src)
	);

	// Decode of a write to one register
	function automatic logic wr_hit(input logic [3:0] a, input logic w,
		input logic [3:0] ofs);
		wr_hit = w && (a == ofs);
	endfunction : wr_hit

	// flag masked until the next second pulse
	assign half_flag = tk.half_sec & ~st_ff.half_clr;

	// Event vector in status bit order
	always_comb begin
		events = 4'h0;
		events[ev_alarm] = st_ff.alarm_pulse;
		events[ev_second] = tk.second_pulse;
		events[ev_minute] = tk.minute_pulse;
		events[ev_half] = tk.half_sec & ~st_ff.half_clr & tk.tick;
	end

	// ------------------------------------------------------------
	// Power-on register: calibration, enable, write enable
	// ------------------------------------------------------------
	always_comb begin
		nxt_cal = cal_ff;
		if (wr_hit(addr, wr, `OFS_CAL_CFG)) begin
			nxt_cal.cal = wdata[`CAL_MSB:`CAL_LSB];
			nxt_cal.wren = wdata[`BIT_WREN];
			// enable bit guarded by write enable
			if (cal_ff.wren) begin
				nxt_cal.clk_en = wdata[`BIT_CLK_EN];
			end
		end
	end

	// only power-on reset clears this register
	always_ff @(posedge clk or negedge por_nrst) begin
		if (!por_nrst) begin
			cal_ff <= '0;
		end else begin
			cal_ff <= nxt_cal;
		end
	end

	// ------------------------------------------------------------
	// Main registers, alarm handling, pin mux, interrupts
	// ------------------------------------------------------------
	always_comb begin
		nxt_st = st_ff;
		nxt_st.alarm_pulse = 1'b0;
		nxt_st.rdata = 16'h0000;

		// Half flag mask releases at the start of each new second
		if (tk.second_pulse) begin
			nxt_st.half_clr = 1'b0;
		end
		// write to low byte of minutes/seconds clears flag
		if (wr_hit(addr, wr, `OFS_MIN_SEC)) begin
			nxt_st.half_clr = 1'b1;
		end

		if (wr_hit(addr, wr, `OFS_PAD_CFG)) begin
			// Reserved select code is the writer's duty; kept as written
			nxt_st.pad = {13'h0, wdata[2:0]};
		end
		if (wr_hit(addr, wr, `OFS_ALARM_CFG)) begin
			nxt_st.alarm = wdata;
		end
		if (wr_hit(addr, wr, `OFS_CTRL)) begin
			nxt_st.osc_sel = wdata[`BIT_OSC_SEL];
		end
		if (wr_hit(addr, wr, `OFS_IRQ_MASK)) begin
			nxt_st.mask = wdata[3:0];
		end

		// Alarm event: only when enabled; a same-cycle write loses only the count or enable bit
		if (alarm_match && st_ff.alarm[`BIT_ALARM_EN]) begin
			nxt_st.alarm_pulse = 1'b1;
			if (st_ff.alarm[`BIT_CHIME]) begin
				// chime wraps count 00 to ff
				nxt_st.alarm[`ALARM_REPEAT_COUNT_MSB:`ALARM_REPEAT_COUNT_LSB] =
					st_ff.alarm[`ALARM_REPEAT_COUNT_MSB:`ALARM_REPEAT_COUNT_LSB] - 8'h01;
			end else if (st_ff.alarm[`ALARM_REPEAT_COUNT_MSB:`ALARM_REPEAT_COUNT_LSB] == 8'h00) begin
				nxt_st.alarm[`BIT_ALARM_EN] = 1'b0;
			end else begin
				nxt_st.alarm[`ALARM_REPEAT_COUNT_MSB:`ALARM_REPEAT_COUNT_LSB] =
					st_ff.alarm[`ALARM_REPEAT_COUNT_MSB:`ALARM_REPEAT_COUNT_LSB] - 8'h01;
			end
		end

		// Sticky status: set wins over write-one-to-clear
		if (wr_hit(addr, wr, `OFS_IRQ_STATUS)) begin
			nxt_st.status = st_ff.status & ~wdata[3:0];
		end
		nxt_st.status = nxt_st.status | events;
		nxt_st.irq = |(nxt_st.status & nxt_st.mask);

		// Output pin multiplexer
		case (out_sel_type'(st_ff.pad[`SEL_MSB:`SEL_LSB]))
			sel_alarm: nxt_st.pin = st_ff.alarm_pulse;
			sel_seconds: nxt_st.pin = tk.sec_clk;
			sel_source: nxt_st.pin = src_lvl;
			default: nxt_st.pin = 1'b0;
		endcase

		// Read data, one cycle after the strobe
		if (rd) begin
			case (addr)
				`OFS_CAL_CFG: nxt_st.rdata = {cal_ff.clk_en, 1'b0,
					cal_ff.wren, 1'b0, half_flag, 3'h0, cal_ff.cal};
				`OFS_PAD_CFG: nxt_st.rdata = st_ff.pad;
				`OFS_ALARM_CFG: nxt_st.rdata = st_ff.alarm;
				`OFS_IRQ_STATUS: nxt_st.rdata = {12'h000, st_ff.status};
				`OFS_IRQ_MASK: nxt_st.rdata = {12'h000, st_ff.mask};
				`OFS_CTRL: nxt_st.rdata = {15'h0, st_ff.osc_sel};
				default: nxt_st.rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign rdata = st_ff.rdata;
	assign clock_output_pin = st_ff.pin;
	assign parallel_port_buffer_select = st_ff.pad[`BIT_PMP_TTL];
	assign irq = st_ff.irq;
endmodule : rtc_cfg

// ---- rtc_cfg_checker.sv ----
// Port-level assertions for the clock configuration block
`timescale 1ns/10ps
`include "rtc_cfg_regs.svh"
module rtc_cfg_checker (
	// Clock and resets
	input wire logic clk,
	input wire logic nrst,
	input wire logic por_nrst,
	// Register port
	input wire logic [3:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [15:0] rdata,
	// Pins
	input wire logic alarm_match,
	input wire logic clock_output_pin,
	input wire logic parallel_port_buffer_select,
	input wire logic irq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst || !por_nrst);
	// A write to one index, read back at once
	sequence s_wr_rd(logic [3:0] a);
		wr && addr == a ##1 rd && addr == a;
	endsequence
	// Seconds write, then config read at once
	sequence s_half_clr;
		wr && addr == `OFS_MIN_SEC ##1 rd && addr == `OFS_CAL_CFG;
	endsequence
	property p_rd_idle;
		!rd |=> rdata == 16'h0000;
	endproperty
	property p_unmapped;
		rd && addr > 4'h6 |=> rdata == 16'h0000;
	endproperty
	// Outputs still quiet at the first edge after release
	property p_reset_quiet;
		$rose(nrst) |-> !irq && !clock_output_pin && rdata == 16'h0000;
	endproperty
	property p_mask_off;
		wr && addr == `OFS_IRQ_MASK && wdata == 16'h0000 |-> ##[1:3] !irq;
	endproperty
	property p_status_clr;
		wr && addr == `OFS_IRQ_STATUS && wdata == 16'h000f |-> ##[1:3] !irq;
	endproperty
	property p_half_clr;
		s_half_clr |=> !rdata[`BIT_HALF_SEC];
	endproperty
	property p_pad_rb;
		s_wr_rd(`OFS_PAD_CFG) |=> rdata == {13'h0, $past(wdata[2:0], 2)};
	endproperty
	// An alarm in the window would legally change the register
	property p_alarm_rb;
		!alarm_match ##0 s_wr_rd(`OFS_ALARM_CFG) ##0 !alarm_match
			|=> rdata == $past(wdata, 2);
	endproperty
	// Exactly one cycle: a later pad write may legally change the pin
	property p_pad_pin;
		wr && addr == `OFS_PAD_CFG && wdata[0]
			|=> parallel_port_buffer_select;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data held");
	a_unmapped: assert property (p_unmapped) else $error("unmapped read");
	a_reset_quiet: assert property (p_reset_quiet) else $error("reset out");
	a_mask_off: assert property (p_mask_off) else $error("irq not masked");
	a_status_clr: assert property (p_status_clr) else $error("irq stuck");
	a_half_clr: assert property (p_half_clr) else $error("half flag");
	a_pad_rb: assert property (p_pad_rb) else $error("pad readback");
	a_alarm_rb: assert property (p_alarm_rb) else $error("alarm readback");
	a_pad_pin: assert property (p_pad_pin) else $error("buffer select pin");
endmodule : rtc_cfg_checker

bind rtc_cfg rtc_cfg_checker u_chk (.clk, .nrst, .por_nrst, .addr, .wdata,
	.wr, .rd, .rdata, .alarm_match, .clock_output_pin,
	.parallel_port_buffer_select, .irq);

// ---- tb_rtc_cfg.sv ----
// Self-checking bench for the clock configuration block
`timescale 1ns/10ps
`include "rtc_cfg_regs.svh"
module tb_rtc_cfg;
	logic clk, nrst, por_nrst, wr, rd, alarm_match;
	logic internal_low_power_rc, secondary_crystal_osc;
	logic [3:0] addr;
	logic [15:0] wdata, rdata;
	logic clock_output_pin, parallel_port_buffer_select, irq;
	int fail_count, checked;
	rtc_cfg u_dut (.clk, .nrst, .por_nrst, .addr, .wdata, .wr, .rd, .rdata,
		.internal_low_power_rc, .secondary_crystal_osc, .alarm_match,
		.clock_output_pin, .parallel_port_buffer_select, .irq);
	// 200 MHz clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task end_of_test;
		$display("checked %0d, fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : end_of_test
	task check16(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: reg %h not %h", $time, got, exp);
		end
	endtask : check16
	task check1(input logic got, input logic exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: pin %b not %b", $time, got, exp);
		end
	endtask : check1
	// Strobe stays up so writes can run back to back
	task wr_reg(input logic [3:0] a, input logic [15:0] d);
		wr <= 1'b1;
		rd <= 1'b0;
		addr <= a;
		wdata <= d;
		@(posedge clk);
	endtask : wr_reg
	task rd_reg(input logic [3:0] a, input logic [15:0] exp);
		wr <= 1'b0;
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		check16(rdata, exp);
		@(posedge clk);
	endtask : rd_reg
	task idle(input int n);
		wr <= 1'b0;
		rd <= 1'b0;
		repeat (n) @(posedge clk);
	endtask : idle
	task pulse_reset(input logic por);
		idle(1);
		nrst <= 1'b0;
		por_nrst <= ~por;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		por_nrst <= 1'b1;
		@(posedge clk);
	endtask : pulse_reset
	// Bounded wait; running out ends the run
	task wait_pin(input logic v);
		int n;
		for (n = 0; n < 20; n++) begin
			@(negedge clk);
			if (clock_output_pin === v) break;
		end
		if (n == 20) begin
			fail_count++;
			end_of_test();
		end else begin
			check1(clock_output_pin, v);
			@(posedge clk);
		end
	endtask : wait_pin
	task alarm_event;
		alarm_match <= 1'b1;
		@(posedge clk);
		alarm_match <= 1'b0;
		wait_pin(1'b1);
	endtask : alarm_event
	task t_reset_vals;
		rd_reg(4'h0, 16'h0000);
		rd_reg(4'h1, 16'h0000);
		rd_reg(4'h2, 16'h0000);
		rd_reg(4'hf, 16'h0000);
	endtask : t_reset_vals
	task t_enable_gate;
		wr_reg(4'h0, 16'h8000);
		rd_reg(4'h0, 16'h0000);
		wr_reg(4'h0, 16'h2000);
		wr_reg(4'h0, 16'ha07f);
		rd_reg(4'h0, 16'ha07f);
		pulse_reset(1'b0);
		rd_reg(4'h0, 16'ha07f);
		pulse_reset(1'b1);
		rd_reg(4'h0, 16'h0000);
	endtask : t_enable_gate
	task t_cal_codes;
		logic [7:0] codes [5];
		logic [15:0] pulses [5];
		codes = '{8'h7f, 8'h01, 8'h00, 8'hff, 8'h80};
		// Pulses added or removed per minute for each code
		pulses = '{16'h01fc, 16'h0004, 16'h0000, 16'h0004, 16'h0200};
		foreach (codes[i]) begin
			wr_reg(4'h0, {8'h20, codes[i]});
			rd_reg(4'h0, {8'h20, codes[i]});
			check16({6'h00, u_dut.u_tick.mag}, pulses[i]);
		end
	endtask : t_cal_codes
	// Runs the timebase to mid-second: one tick per four clocks
	task t_half;
		int n;
		logic ok;
		wr_reg(4'h0, 16'h0800);
		rd_reg(4'h0, 16'h0000);
		pulse_reset(1'b0);
		wr_reg(4'h1, 16'h0002);
		wr_reg(4'h0, 16'h2000);
		wr_reg(4'h0, 16'ha000);
		idle(3);
		check1(clock_output_pin, 1'b1);
		for (n = 0; n < 17000; n++) begin
			internal_low_power_rc <= 1'b1;
			repeat (2) @(posedge clk);
			internal_low_power_rc <= 1'b0;
			@(posedge clk);
			@(negedge clk);
			if (clock_output_pin === 1'b0) break;
			@(posedge clk);
		end
		@(posedge clk);
		if (n == 17000) begin
			fail_count++;
			end_of_test();
		end else begin
			// Seconds clock falls once half a second of ticks is in
			ok = (n >= `HALF_SEC_TICKS) && (n <= `HALF_SEC_TICKS + 1);
			check1(ok, 1'b1);
		end
		rd_reg(4'h0, 16'ha800);
		wr_reg(4'h3, 16'h0000);
		rd_reg(4'h0, 16'ha000);
		// Stop the timebase so later status checks see no events
		wr_reg(4'h0, 16'h2000);
	endtask : t_half
	task t_source;
		wr_reg(4'h1, 16'h0005);
		rd_reg(4'h1, 16'h0005);
		check1(parallel_port_buffer_select, 1'b1);
		wr_reg(4'h6, 16'h0000);
		idle(1);
		internal_low_power_rc <= 1'b1;
		wait_pin(1'b1);
		internal_low_power_rc <= 1'b0;
		wait_pin(1'b0);
		wr_reg(4'h6, 16'h0001);
		idle(1);
		secondary_crystal_osc <= 1'b1;
		wait_pin(1'b1);
		secondary_crystal_osc <= 1'b0;
		wait_pin(1'b0);
	endtask : t_source
	task t_alarm;
		wr_reg(4'h2, 16'h3d05);
		rd_reg(4'h2, 16'h3d05);
		wr_reg(4'h1, 16'h0000);
		wr_reg(4'h5, 16'h0001);
		wr_reg(4'h2, 16'h8000);
		idle(1);
		alarm_event();
		rd_reg(4'h2, 16'h0000);
		check1(irq, 1'b1);
		wr_reg(4'h4, 16'h000f);
		idle(3);
		check1(irq, 1'b0);
		wr_reg(4'h5, 16'h0000);
		wr_reg(4'h2, 16'h8002);
		idle(1);
		alarm_event();
		rd_reg(4'h2, 16'h8001);
		check1(irq, 1'b0);
		wr_reg(4'h5, 16'h0001);
		idle(3);
		check1(irq, 1'b1);
		wr_reg(4'h4, 16'h000f);
		wr_reg(4'h2, 16'hc000);
		idle(1);
		alarm_event();
		rd_reg(4'h2, 16'hc0ff);
	endtask : t_alarm
	// Main sequence
	initial begin
		fail_count = 0;
		checked = 0;
		nrst = 1'b0;
		por_nrst = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		addr = 4'h0;
		wdata = 16'h0000;
		internal_low_power_rc = 1'b0;
		secondary_crystal_osc = 1'b0;
		alarm_match = 1'b0;
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		por_nrst <= 1'b1;
		t_reset_vals();
		t_enable_gate();
		t_cal_codes();
		t_half();
		t_source();
		t_alarm();
		idle(2);
		end_of_test();
	end
endmodule : tb_rtc_cfg
